// *** bench/ispr_core_model.sv ***
// Processor core model that counts the requests it receives
`timescale 1ns/10ps
module ispr_core_model (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Gated request from the block
	input wire logic i_core_req,
	// Cycles in which a request was seen
	output logic [15:0] o_taken
);
	// Core samples the request level on every rising edge, like a real pin
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_taken <= 16'h0000;
		else if (i_core_req)
			o_taken <= o_taken + 16'h0001;
	end
endmodule : ispr_core_model

// *** bench/ispr_top_test.sv ***
// Self-checking bench for the status and proximity reload block
`timescale 1ns/10ps
module ispr_top_test;
	// Clock, reset and register bus
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	// Presentation and timer path
	logic pv = 1'b0;
	logic [2:0] pp = 3'h0;
	logic [5:0] pvec = 6'h00;
	logic trig = 1'b0;
	logic irq = 1'b0;
	logic core_req;
	logic active;
	logic [15:0] taken;
	logic [15:0] seed = 16'h0015;
	logic [15:0] snap;
	int err_total = 0;
	int num_checks = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	ispr_top uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wr(wr), .i_rd(rd),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
		.i_present_valid(pv), .i_present_prio(pp), .i_present_vec(pvec),
		.i_prox_trigger(trig), .i_irq_req(irq), .o_core_req(core_req),
		.o_prox_active(active));
	ispr_core_model core (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_core_req(core_req), .o_taken(taken));

	// Shift register for repeatable stimulus
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Expected status word; unused bits are zero
	function automatic logic [31:0] stat(input logic [2:0] p,
		input logic [5:0] v);
		stat = {21'h000000, p, 2'h0, v};
	endfunction : stat

	// Compare and count
	task automatic chk(input string n, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk

	// One-cycle write
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr

	// One-cycle read; data stand only in the following cycle
	task automatic bus_chk(input logic [7:0] a, input logic [31:0] e,
		input string n);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, rdata, e);
	endtask : bus_chk

	// Controller presents one interrupt for a single cycle
	task automatic present(input logic [2:0] p, input logic [5:0] v);
		@(posedge clk);
		pv <= 1'b1;
		pp <= p;
		pvec <= v;
		@(posedge clk);
		pv <= 1'b0;
	endtask : present

	// Write then read of one word, strobes back to back
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
		input string n);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, rdata, d);
	endtask : wr_rd

	// Presentation followed at once by a status read
	task automatic present_rd(input logic [2:0] p, input logic [5:0] v);
		@(posedge clk);
		pv <= 1'b1;
		pp <= p;
		pvec <= v;
		@(posedge clk);
		pv <= 1'b0;
		rd <= 1'b1;
		addr <= ispr_pkg::ISPR_OFS_STATUS;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("stb", rdata, stat(p, v));
	endtask : present_rd

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// Main sequence; bench plays software in single-vector mode
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		bus_chk(ispr_pkg::ISPR_OFS_STATUS, 32'h0000_0000, "st0");
		bus_chk(ispr_pkg::ISPR_OFS_RELOAD, 32'h0000_0000, "rl0");
		// Random presentations, then the all-ones corner
		repeat (8)
		begin
			seed = lfsr(seed);
			present_rd(seed[2:0], seed[8:3]);
		end
		present(3'h7, 6'h3f);
		bus_chk(8'h00, 32'h0000_073f, "stmax");
		// A presentation beats a status write in the same cycle
		@(posedge clk);
		wr <= 1'b1;
		addr <= 8'h00;
		wdata <= 32'h0000_0215;
		pv <= 1'b1;
		pp <= 3'h5;
		pvec <= 6'h09;
		@(posedge clk);
		wr <= 1'b0;
		pv <= 1'b0;
		bus_chk(8'h00, stat(3'h5, 6'h09), "race");
		// Writes to unused status bits leave no trace
		bus_wr(8'h00, 32'hffff_f8c0);
		bus_chk(8'h00, 32'h0000_0000, "stw");
		bus_chk(8'h0c, 32'h0000_0000, "unmap");
		// A trigger with reload zero is ignored
		@(posedge clk);
		irq <= 1'b1;
		trig <= 1'b1;
		@(posedge clk) trig <= 1'b0;
		#1 chk("idle", {31'h0, active}, 32'h0000_0000);
		seed = lfsr(seed);
		wr_rd(8'h04, {seed, ~seed}, "rl");
		// Reload of three defers the core for exactly three cycles
		bus_wr(8'h04, 32'h0000_0003);
		@(posedge clk) trig <= 1'b1;
		@(posedge clk) trig <= 1'b0;
		#1 snap = taken;
		repeat (3)
		begin
			chk("act", {30'h0, active, core_req}, 32'h0000_0002);
			@(posedge clk);
			#1;
		end
		chk("held", {16'h0, taken}, {16'h0, snap});
		chk("rel", {30'h0, active, core_req}, 32'h0000_0001);
		bus_chk(8'h08, 32'h0000_0000, "cnt");
		// Reset in mid-run clears the reload word again
		@(posedge clk) rst_b <= 1'b0;
		@(posedge clk) rst_b <= 1'b1;
		bus_chk(8'h04, 32'h0000_0000, "rl_rst");
		final_report();
	end

	// Watchdog at 2500 cycles, far beyond the some 60 cycles the tests need
	initial
	begin
		#100000;
		err_total++;
		final_report();
	end
endmodule : ispr_top_test

// *** design/ispr_pkg.sv ***
// Shared constants and types for the interrupt status and proximity block
package ispr_pkg;

	// Register bus geometry
	localparam int ISPR_ADDR_W = 8;
	localparam int ISPR_DATA_W = 32;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] ISPR_OFS_STATUS = 8'h00;
	localparam logic [7:0] ISPR_OFS_RELOAD = 8'h04;
	localparam logic [7:0] ISPR_OFS_COUNT = 8'h08;

	// Status register field layout
	localparam int ISPR_PRIO_W = 3;
	localparam int ISPR_PRIO_LSB = 8;
	localparam int ISPR_PRIO_MSB = 10;
	localparam int ISPR_VEC_W = 6;
	localparam int ISPR_VEC_LSB = 0;
	localparam int ISPR_VEC_MSB = 5;

	// Reset values
	localparam logic [2:0] ISPR_PRIO_RST = 3'h0;
	localparam logic [5:0] ISPR_VEC_RST = 6'h00;
	localparam logic [31:0] ISPR_RELOAD_RST = 32'h0000_0000;
	localparam logic [31:0] ISPR_WORD_ZERO = 32'h0000_0000;

	// Timer step and terminal values
	localparam logic [31:0] ISPR_COUNT_ONE = 32'h0000_0001;

	// One interrupt presented to the core by the controller
	typedef struct packed {
		logic valid;
		logic [ISPR_PRIO_W-1:0] prio;
		logic [ISPR_VEC_W-1:0] vec;
	} ispr_present_type;

	// One register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ISPR_ADDR_W-1:0] addr;
		logic [ISPR_DATA_W-1:0] wdata;
	} ispr_bus_type;

	// Proximity timer states
	typedef enum logic {
		ISPR_PROX_IDLE,
		ISPR_PROX_COUNT
	} ispr_prox_state_type;

	// Whole state of the register block
	typedef struct packed {
		logic [ISPR_PRIO_W-1:0] prio;
		logic [ISPR_VEC_W-1:0] vec;
		logic [ISPR_DATA_W-1:0] reload;
		logic [ISPR_DATA_W-1:0] rdata;
	} ispr_regs_type;

	// Whole state of the proximity timer
	typedef struct packed {
		ispr_prox_state_type fsm;
		logic [ISPR_DATA_W-1:0] count;
	} ispr_timer_type;

endpackage : ispr_pkg

// *** design/ispr_prox_timer.sv ***
// Interrupt proximity timer that defers core requests while it runs
`timescale 1ns/10ps
module ispr_prox_timer #(
	parameter int DATA_W = ispr_pkg::ISPR_DATA_W
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Trigger and reload value
	input wire logic i_trigger,
	input wire logic [DATA_W-1:0] i_reload,
	// Request from the controller, and the gated one to the core
	input wire logic i_req,
	output logic o_core_req,
	// Timer state for software
	output logic [DATA_W-1:0] o_count,
	output logic o_active
);

	// Registered state and its next value
	ispr_pkg::ispr_timer_type st;
	ispr_pkg::ispr_timer_type next_st;

	// Next-state logic of the timer
	always_comb
	begin
		next_st = st;
		unique case (st.fsm)
			// A trigger with a non-zero reload starts the countdown
			ispr_pkg::ISPR_PROX_IDLE:
			begin
				if (i_trigger && (i_reload != ispr_pkg::ISPR_WORD_ZERO))
				begin
					next_st.count = i_reload; // R4
					next_st.fsm = ispr_pkg::ISPR_PROX_COUNT;
				end
			end
			// Retriggers are ignored so a burst cannot starve the core
			ispr_pkg::ISPR_PROX_COUNT:
			begin
				next_st.count = st.count - ispr_pkg::ISPR_COUNT_ONE; // R6
				if (st.count == ispr_pkg::ISPR_COUNT_ONE)
				begin
					next_st.fsm = ispr_pkg::ISPR_PROX_IDLE; // R6
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st.fsm <= ispr_pkg::ISPR_PROX_IDLE;
			st.count <= ispr_pkg::ISPR_WORD_ZERO;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Requests pass only while the timer stands idle
	assign o_active = (st.fsm == ispr_pkg::ISPR_PROX_COUNT);
	assign o_core_req = i_req && !o_active; // R6
	assign o_count = st.count;

	// Start loads exactly the reload value
	property p_load;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!o_active && i_trigger && i_reload != ispr_pkg::ISPR_WORD_ZERO)
		|=> (o_active && o_count == $past(i_reload));
	endproperty
	a_load: assert property (p_load) else $error("reload not loaded"); // R4

	// Last count step ends deferral and lets requests through
	property p_release;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(o_active && o_count == ispr_pkg::ISPR_COUNT_ONE)
		|=> (!o_active && o_count == ispr_pkg::ISPR_WORD_ZERO
		&& o_core_req == i_req);
	endproperty
	a_release: assert property (p_release) else $error("no release"); // R6

	// While counting, every step but the last lowers the count by one and blocks
	property p_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(o_active && o_count != ispr_pkg::ISPR_COUNT_ONE)
		|=> (o_active && !o_core_req
		&& o_count == $past(o_count) - ispr_pkg::ISPR_COUNT_ONE);
	endproperty
	a_hold: assert property (p_hold) else $error("bad countdown"); // R6

endmodule : ispr_prox_timer

// *** design/ispr_top.sv ***
// Interrupt status register and proximity reload register block
// Behaviour
// [R1] Status bits 10:8 hold latest presented priority
// [R2] Status bits 5:0 hold presented vector number
// [R3] Software trusts fields only in single-vector mode
// [R4] Reload register value loads the proximity timer
// [R5] Status bits 31:11 and 7:6 read zero
// [R6] Timer counts down, then releases deferred requests
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module ispr_top #(
	parameter int ADDR_W = ispr_pkg::ISPR_ADDR_W,
	parameter int DATA_W = ispr_pkg::ISPR_DATA_W
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Register bus
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	output logic [DATA_W-1:0] o_rdata,
	// Interrupt presented to the core by the controller
	input wire logic i_present_valid,
	input wire logic [ispr_pkg::ISPR_PRIO_W-1:0] i_present_prio,
	input wire logic [ispr_pkg::ISPR_VEC_W-1:0] i_present_vec,
	// Proximity timer trigger and request path
	input wire logic i_prox_trigger,
	input wire logic i_irq_req,
	output logic o_core_req,
	output logic o_prox_active
);

	// Bundled inputs
	ispr_pkg::ispr_present_type pres;
	ispr_pkg::ispr_bus_type bus;

	// Registered state and its next value
	ispr_pkg::ispr_regs_type st;
	ispr_pkg::ispr_regs_type next_st;

	// Timer count seen by software
	logic [DATA_W-1:0] prox_count;

	// Word image of the status register
	logic [DATA_W-1:0] status_word;

	// Address decode, used by both the write and the read path
	function automatic logic hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0] ofs
	);
		hit = (addr == ADDR_W'(ofs));
	endfunction : hit

	// Gather the ports into their carriers
	always_comb
	begin
		pres.valid = i_present_valid;
		pres.prio = i_present_prio;
		pres.vec = i_present_vec;
		bus.wr = i_wr;
		bus.rd = i_rd;
		bus.addr = i_addr;
		bus.wdata = i_wdata;
	end

	// Status image: only the two fields are driven, the rest is zero
	always_comb
	begin
		status_word = ispr_pkg::ISPR_WORD_ZERO; // R5
		status_word[ispr_pkg::ISPR_PRIO_MSB:ispr_pkg::ISPR_PRIO_LSB] =
			st.prio; // R1
		status_word[ispr_pkg::ISPR_VEC_MSB:ispr_pkg::ISPR_VEC_LSB] =
			st.vec; // R2
	end

	// Next-state logic for registers and read data
	always_comb
	begin
		next_st = st;
		// Read data stand for one cycle only, zero otherwise
		next_st.rdata = ispr_pkg::ISPR_WORD_ZERO;
		// Software write to the status fields; reserved bits not stored
		if (bus.wr && hit(bus.addr, ispr_pkg::ISPR_OFS_STATUS))
		begin
			next_st.prio = bus.wdata[ispr_pkg::ISPR_PRIO_MSB:
				ispr_pkg::ISPR_PRIO_LSB]; // R5
			next_st.vec = bus.wdata[ispr_pkg::ISPR_VEC_MSB:
				ispr_pkg::ISPR_VEC_LSB]; // R5
		end
		// Software write to the reload value
		if (bus.wr && hit(bus.addr, ispr_pkg::ISPR_OFS_RELOAD))
		begin
			next_st.reload = bus.wdata; // R4
		end
		// A presentation in the same cycle beats a software write,
		// so the status never loses the event that just happened
		if (pres.valid)
		begin
			next_st.prio = pres.prio; // R1
			next_st.vec = pres.vec; // R2
		end
		// Read mux; unmapped addresses answer zero
		if (bus.rd)
		begin
			if (hit(bus.addr, ispr_pkg::ISPR_OFS_STATUS))
			begin
				next_st.rdata = status_word; // R5
			end
			else if (hit(bus.addr, ispr_pkg::ISPR_OFS_RELOAD))
			begin
				next_st.rdata = st.reload;
			end
			else if (hit(bus.addr, ispr_pkg::ISPR_OFS_COUNT))
			begin
				next_st.rdata = prox_count;
			end
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st.prio <= ispr_pkg::ISPR_PRIO_RST;
			st.vec <= ispr_pkg::ISPR_VEC_RST;
			st.reload <= ispr_pkg::ISPR_RELOAD_RST;
			st.rdata <= ispr_pkg::ISPR_WORD_ZERO;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Read data come straight from a flip-flop
	assign o_rdata = st.rdata;

	// Proximity timer fed by the reload register
	ispr_prox_timer #(
		.DATA_W(DATA_W)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_trigger(i_prox_trigger),
		.i_reload(st.reload), // R4
		.i_req(i_irq_req),
		.o_core_req(o_core_req),
		.o_count(prox_count),
		.o_active(o_prox_active)
	);

	// Presented priority appears in the status one cycle later
	property p_prio;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_present_valid |=> (st.prio == $past(i_present_prio));
	endproperty
	a_prio: assert property (p_prio) else $error("priority lost"); // R1

	// Presented vector appears, and a status read shows it
	property p_vec;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_present_valid && !i_rd)
		##1 (i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS)
		&& !i_present_valid)
		|=> (o_rdata[ispr_pkg::ISPR_VEC_MSB:ispr_pkg::ISPR_VEC_LSB]
		== $past(i_present_vec, 2));
	endproperty
	a_vec: assert property (p_vec) else $error("vector lost"); // R2

	// Status reads never show reserved bits
	property p_zero;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS))
		|=> (o_rdata[31:11] == 21'h000000 && o_rdata[7:6] == 2'h0);
	endproperty
	a_zero: assert property (p_zero) else $error("reserved set"); // R5

	// A reload write is read back the next cycle
	property p_reload;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_RELOAD))
		##1 (i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_RELOAD) && !i_wr)
		|=> (o_rdata == $past(i_wdata, 2));
	endproperty
	a_reload: assert property (p_reload) else $error("bad reload"); // R4

	// No request reaches the core while the timer defers
	property p_defer;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_prox_active |-> !o_core_req;
	endproperty
	a_defer: assert property (p_defer) else $error("not deferred"); // R6

	// Priority holds without a presentation or a status write
	property p_prio_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!i_present_valid
		&& !(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS)))
		|=> (st.prio == $past(st.prio));
	endproperty
	a_prio_hold: assert property (p_prio_hold) else $error("prio moved"); // R1

	// Vector holds without a presentation or a status write
	property p_vec_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!i_present_valid
		&& !(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS)))
		|=> (st.vec == $past(st.vec));
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vec moved"); // R2

	// A status write alone stores the written priority field
	property p_prio_wr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS)
		&& !i_present_valid)
		|=> (st.prio == $past(i_wdata[ispr_pkg::ISPR_PRIO_MSB:
		ispr_pkg::ISPR_PRIO_LSB]));
	endproperty
	a_prio_wr: assert property (p_prio_wr) else $error("prio write"); // R1

	// A status write alone stores the written vector field
	property p_vec_wr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS)
		&& !i_present_valid)
		|=> (st.vec == $past(i_wdata[ispr_pkg::ISPR_VEC_MSB:
		ispr_pkg::ISPR_VEC_LSB]));
	endproperty
	a_vec_wr: assert property (p_vec_wr) else $error("vec write"); // R2

	// A status read shows the stored priority in its field
	property p_prio_rd;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS))
		|=> (o_rdata[ispr_pkg::ISPR_PRIO_MSB:ispr_pkg::ISPR_PRIO_LSB]
		== $past(st.prio));
	endproperty
	a_prio_rd: assert property (p_prio_rd) else $error("prio read"); // R1

	// A status read shows the stored vector in its field
	property p_vec_rd;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_STATUS))
		|=> (o_rdata[ispr_pkg::ISPR_VEC_MSB:ispr_pkg::ISPR_VEC_LSB]
		== $past(st.vec));
	endproperty
	a_vec_rd: assert property (p_vec_rd) else $error("vec read"); // R2

	// Reload value only changes on a reload write
	property p_reload_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		!(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_RELOAD))
		|=> (st.reload == $past(st.reload));
	endproperty
	a_reload_hold: assert property (p_reload_hold) else $error("reload moved"); // R4

	// A reload write stores the whole word
	property p_reload_wr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_wr && hit(i_addr, ispr_pkg::ISPR_OFS_RELOAD))
		|=> (st.reload == $past(i_wdata));
	endproperty
	a_reload_wr: assert property (p_reload_wr) else $error("reload write"); // R4

	// A reload read returns the stored word
	property p_reload_rd;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_RELOAD))
		|=> (o_rdata == $past(st.reload));
	endproperty
	a_reload_rd: assert property (p_reload_rd) else $error("reload read"); // R4

	// A count read returns the timer count of the read cycle
	property p_count_rd;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_rd && hit(i_addr, ispr_pkg::ISPR_OFS_COUNT))
		|=> (o_rdata == $past(prox_count));
	endproperty
	a_count_rd: assert property (p_count_rd) else $error("count read"); // R6

	// Unmapped reads answer zero so no stray bits reach software
	property p_unmapped;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_rd && !hit(i_addr, ispr_pkg::ISPR_OFS_STATUS)
		&& !hit(i_addr, ispr_pkg::ISPR_OFS_RELOAD)
		&& !hit(i_addr, ispr_pkg::ISPR_OFS_COUNT))
		|=> (o_rdata == ispr_pkg::ISPR_WORD_ZERO);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data"); // R5

	// Read data fall back to zero when no read was made
	property p_rd_idle;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		!i_rd |=> (o_rdata == ispr_pkg::ISPR_WORD_ZERO);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stale data"); // R5

	// A trigger with a non-zero reload starts the deferral
	property p_start;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!o_prox_active && i_prox_trigger
		&& st.reload != ispr_pkg::ISPR_WORD_ZERO)
		|=> o_prox_active;
	endproperty
	a_start: assert property (p_start) else $error("no start"); // R4

	// A trigger with a zero reload leaves the timer idle
	property p_zero_trig;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!o_prox_active && i_prox_trigger
		&& st.reload == ispr_pkg::ISPR_WORD_ZERO)
		|=> !o_prox_active;
	endproperty
	a_zero_trig: assert property (p_zero_trig) else $error("zero started"); // R6

	// With the timer idle the request reaches the core untouched
	property p_pass;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		!o_prox_active |-> (o_core_req == i_irq_req);
	endproperty
	a_pass: assert property (p_pass) else $error("request lost"); // R6

endmodule : ispr_top
